// ---- src/boundary_scan_tap.v ----
// boundary-scan test access port: tap controller, instruction, bypass and boundary registers
// assumes the test clock and all pins are asynchronous and oversampled by i_clk (tck high for at least 3 clk and low for at least 2 clk)
`timescale 1ns/10ps
`include "bscan_defs.vh"

module boundary_scan_tap #(
   parameter BSR_LEN = `BSR_LEN_DEF,
   parameter FIFO_D  = `FIFO_D_DEF,
   parameter FIFO_AW = `FIFO_AW_DEF
) (
   // clock and reset
   input  wire               i_clk,
   input  wire               i_rst_n,
   // serial test port
   input  wire               i_tck,
   input  wire               i_tms,
   input  wire               i_tdi,
   input  wire               i_trst_n,
   output reg                o_tdo,
   output reg                o_tdo_oe_n,
   // device status
   input  wire               i_config_busy,
   input  wire               i_scan_disable,
   input  wire               i_power_ok,
   // core and pin side
   input  wire [BSR_LEN-1:0] i_core_out,
   input  wire [BSR_LEN-1:0] i_core_oe_n,
   input  wire [BSR_LEN-1:0] i_pin_in,
   output reg  [BSR_LEN-1:0] o_pin_out,
   output reg  [BSR_LEN-1:0] o_pin_oe_n,
   output wire [BSR_LEN-1:0] o_core_in,
   // status
   output reg                o_overrun,
   output wire [3:0]         o_tap_state
);
   reg  [`SYN_W-1:0]   syn1_r;
   reg  [`SYN_W-1:0]   syn2_r;
   reg  [`SYN_W-1:0]   syn3_r;
   reg  [`SYN_W-1:0]   filt_r;
   wire [`SYN_W-1:0]   filt_nxt;
   reg                 tck_prev_r;
   wire                tck_rise;
   wire                tck_fall;
   wire                lockout;
   wire                fifo_in_ready;
   wire                fifo_out_valid;
   wire [1:0]          fifo_out_data;
   reg                 eng_ready_r;
   wire                step;
   wire                tms_s;
   wire                tdi_s;
   reg  [3:0]          state_r;
   reg  [3:0]          state_nxt;
   reg  [`IR_LEN-1:0]  ir_shift_r;
   reg  [`IR_LEN-1:0]  ir_r;
   reg                 bypass_r;
   reg  [BSR_LEN-1:0]  bsr_shift_r;
   reg  [BSR_LEN-1:0]  bsr_upd_r;
   wire                tdo_src;
   wire                shifting;
   wire                sel_bsr;
   wire                extest;

   // three-stage synchronisers; a change counts once stages two and three agree
   assign filt_nxt = (syn2_r & ~(syn2_r ^ syn3_r)) | (filt_r & (syn2_r ^ syn3_r));

   // reset value of one on tms, tdi and trst_n makes a floating test input read high
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         syn1_r     <= `SYN_RST_VAL;
         syn2_r     <= `SYN_RST_VAL;
         syn3_r     <= `SYN_RST_VAL;
         filt_r     <= `SYN_RST_VAL;
         tck_prev_r <= 1'b0;
      end else begin
         syn1_r     <= {i_power_ok, i_scan_disable, i_config_busy, i_trst_n, i_tdi, i_tms, i_tck};
         syn2_r     <= syn1_r;
         syn3_r     <= syn2_r;
         filt_r     <= filt_nxt;
         tck_prev_r <= filt_r[`SYN_TCK];
      end
   end

   assign tck_rise = filt_r[`SYN_TCK] & ~tck_prev_r;
   assign tck_fall = ~filt_r[`SYN_TCK] & tck_prev_r;

   // scanning locked out while configuring unless scan support is switched off for user mode
   assign lockout = filt_r[`SYN_CFG_BUSY] & ~filt_r[`SYN_SCAN_DIS];

   // tms/tdi pairs taken at each tck rise wait here until the engine is free
   bscan_fifo #(
      .WIDTH (`FIFO_W_DEF),
      .DEPTH (FIFO_D),
      .AW    (FIFO_AW)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (tck_rise),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({filt_r[`SYN_TDI], filt_r[`SYN_TMS]}),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (eng_ready_r),
      .o_out_data  (fifo_out_data)
   );

   // engine stalls until the previous result has been shown on tdo
   assign step  = fifo_out_valid & eng_ready_r;
   assign tms_s = fifo_out_data[0];
   assign tdi_s = fifo_out_data[1];

   // a lost tck edge is sticky; the link cannot be slowed from here
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_overrun <= 1'b0;
      end else if (tck_rise & ~fifo_in_ready) begin
         o_overrun <= 1'b1;
      end
   end

   // sixteen-state controller transitions
   always @* begin
      case (state_r)
         `ST_TLR:      state_nxt = tms_s ? `ST_TLR      : `ST_RTI;
         `ST_RTI:      state_nxt = tms_s ? `ST_SEL_DR   : `ST_RTI;
         `ST_SEL_DR:   state_nxt = tms_s ? `ST_SEL_IR   : `ST_CAP_DR;
         `ST_CAP_DR:   state_nxt = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
         `ST_SHIFT_DR: state_nxt = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
         `ST_EXIT1_DR: state_nxt = tms_s ? `ST_UPD_DR   : `ST_PAUSE_DR;
         `ST_PAUSE_DR: state_nxt = tms_s ? `ST_EXIT2_DR : `ST_PAUSE_DR;
         `ST_EXIT2_DR: state_nxt = tms_s ? `ST_UPD_DR   : `ST_SHIFT_DR;
         `ST_UPD_DR:   state_nxt = tms_s ? `ST_SEL_DR   : `ST_RTI;
         `ST_SEL_IR:   state_nxt = tms_s ? `ST_TLR      : `ST_CAP_IR;
         `ST_CAP_IR:   state_nxt = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
         `ST_SHIFT_IR: state_nxt = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
         `ST_EXIT1_IR: state_nxt = tms_s ? `ST_UPD_IR   : `ST_PAUSE_IR;
         `ST_PAUSE_IR: state_nxt = tms_s ? `ST_EXIT2_IR : `ST_PAUSE_IR;
         `ST_EXIT2_IR: state_nxt = tms_s ? `ST_UPD_IR   : `ST_SHIFT_IR;
         `ST_UPD_IR:   state_nxt = tms_s ? `ST_SEL_DR   : `ST_RTI;
         default:      state_nxt = `ST_TLR;
      endcase
   end

   assign o_tap_state = state_r;
   assign extest      = (ir_r == `OP_EXTEST);
   assign sel_bsr     = extest | (ir_r == `OP_SAMPLE);

   // tdo shows the register of the state entered at the last rise; the engine steps before that fall
   assign shifting = (state_r == `ST_SHIFT_IR) | (state_r == `ST_SHIFT_DR);
   assign tdo_src  = (state_r == `ST_SHIFT_IR) ? ir_shift_r[0] : (sel_bsr ? bsr_shift_r[0] : bypass_r);

   // tap engine: one step per buffered tck rise
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r       <= `ST_TLR;
         ir_shift_r    <= `OP_BYPASS;
         ir_r          <= `OP_BYPASS;
         bypass_r      <= 1'b0;
         bsr_shift_r   <= {BSR_LEN{1'b0}};
         bsr_upd_r     <= {BSR_LEN{1'b0}};
      end else if (~filt_r[`SYN_TRST_N] | lockout) begin
         state_r       <= `ST_TLR;
         ir_r          <= `OP_BYPASS;
      end else if (step) begin
         state_r <= state_nxt;
         case (state_r)
            `ST_TLR: begin
               ir_r <= `OP_BYPASS;
            end
            `ST_CAP_IR: begin
               ir_shift_r <= `IR_CAPTURE_VAL;
            end
            `ST_SHIFT_IR: begin
               ir_shift_r <= {tdi_s, ir_shift_r[`IR_LEN-1:1]};
            end
            `ST_UPD_IR: begin
               ir_r <= ir_shift_r;
            end
            `ST_CAP_DR: begin
               bypass_r <= 1'b0;
               if (sel_bsr) begin
                  bsr_shift_r <= i_pin_in;
               end
            end
            `ST_SHIFT_DR: begin
               if (sel_bsr) begin
                  bsr_shift_r <= {tdi_s, bsr_shift_r[BSR_LEN-1:1]};
               end else begin
                  bypass_r <= tdi_s;
               end
            end
            `ST_UPD_DR: begin
               if (sel_bsr) begin
                  bsr_upd_r <= bsr_shift_r;
               end
            end
            default: begin
               bypass_r <= bypass_r;
            end
         endcase
      end
   end

   // tdo changes on the falling test clock, which also frees the engine
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tdo       <= 1'b1;
         o_tdo_oe_n  <= 1'b1;
         eng_ready_r <= 1'b1;
      end else begin
         if (step) begin
            eng_ready_r <= 1'b0;
         end else if (tck_fall) begin
            eng_ready_r <= 1'b1;
         end
         // test reset or lockout releases tdo at once, not at the next fall
         if (~filt_r[`SYN_TRST_N] | lockout) begin
            o_tdo_oe_n <= 1'b1;
         end else if (tck_fall) begin
            o_tdo      <= tdo_src;
            o_tdo_oe_n <= ~shifting;
         end
      end
   end

   // core keeps seeing live pins in every instruction; capture never stops it
   assign o_core_in = i_pin_in;

   // pin drivers: off until power is good, update stage under extest, core otherwise
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pin_out  <= {BSR_LEN{1'b0}};
         o_pin_oe_n <= {BSR_LEN{1'b1}};
      end else if (~filt_r[`SYN_PWR_OK]) begin
         o_pin_out  <= {BSR_LEN{1'b0}};
         o_pin_oe_n <= {BSR_LEN{1'b1}};
      end else if (extest) begin
         o_pin_out  <= bsr_upd_r;
         o_pin_oe_n <= {BSR_LEN{1'b0}};
      end else begin
         o_pin_out  <= i_core_out;
         o_pin_oe_n <= i_core_oe_n;
      end
   end
endmodule // boundary_scan_tap

// ---- include/bscan_defs.vh ----
// constants for the boundary-scan test access port
// assumes a single 25 MHz system clock that oversamples the test clock
`ifndef BSCAN_DEFS_VH
`define BSCAN_DEFS_VH

// instruction register
`define IR_LEN          3
`define OP_EXTEST       3'h0
`define OP_SAMPLE       3'h1
`define OP_BYPASS       3'h7
`define IR_CAPTURE_VAL  3'h1

// boundary register length of the default variant
`define BSR_LEN_DEF     522

// tap controller state codes
`define ST_TLR          4'hF
`define ST_RTI          4'hC
`define ST_SEL_DR       4'h7
`define ST_CAP_DR       4'h6
`define ST_SHIFT_DR     4'h2
`define ST_EXIT1_DR     4'h1
`define ST_PAUSE_DR     4'h3
`define ST_EXIT2_DR     4'h0
`define ST_UPD_DR       4'h5
`define ST_SEL_IR       4'h4
`define ST_CAP_IR       4'hE
`define ST_SHIFT_IR     4'hA
`define ST_EXIT1_IR     4'h9
`define ST_PAUSE_IR     4'hB
`define ST_EXIT2_IR     4'h8
`define ST_UPD_IR       4'hD

// synchroniser bit positions and reset levels
`define SYN_W           7
`define SYN_TCK         0
`define SYN_TMS         1
`define SYN_TDI         2
`define SYN_TRST_N      3
`define SYN_CFG_BUSY    4
`define SYN_SCAN_DIS    5
`define SYN_PWR_OK      6
`define SYN_RST_VAL     7'h0E

// sampled test bits buffered between edge finder and tap engine
`define FIFO_W_DEF      2
`define FIFO_D_DEF      16
`define FIFO_AW_DEF     4

`endif

// ---- src/bscan_fifo.v ----
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth is a power of two given by its address width
`timescale 1ns/10ps
module bscan_fifo #(
   parameter WIDTH = 2,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // clock and reset
   input  wire             i_clk,
   input  wire             i_rst_n,
   // fill side
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   // drain side
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output reg  [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr_r;
   reg [AW:0]      rd_ptr_r;
   reg             out_valid_r;
   wire            empty;
   wire            push;
   wire            pop_mem;

   // extra pointer bit tells full from empty
   assign empty       = (wr_ptr_r == rd_ptr_r);
   assign o_in_ready  = ~((wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]));
   assign push        = i_in_valid & o_in_ready;
   assign o_out_valid = out_valid_r;
   // output stage refills when empty or being taken
   assign pop_mem     = ~empty & (~out_valid_r | i_out_ready);

   // storage write
   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= i_in_data;
      end
   end

   // pointers and registered output word
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r    <= {(AW+1){1'b0}};
         rd_ptr_r    <= {(AW+1){1'b0}};
         out_valid_r <= 1'b0;
         o_out_data  <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop_mem) begin
            rd_ptr_r    <= rd_ptr_r + 1'b1;
            o_out_data  <= mem[rd_ptr_r[AW-1:0]];
            out_valid_r <= 1'b1;
         end else if (i_out_ready) begin
            out_valid_r <= 1'b0;
         end
      end
   end
endmodule // bscan_fifo

// ---- tb/boundary_scan_tap_chk.sv ----
// assertions on the boundary-scan port, seen from its top-level pins only
// assumes the test clock is slow and oversampled by i_clk; bound to every dut
`timescale 1ns/10ps
`include "bscan_defs.vh"
module boundary_scan_tap_chk #(
   parameter BSR_LEN = 8
) (
   // clock and reset
   input wire               i_clk,
   input wire               i_rst_n,
   // serial test port
   input wire               i_tck,
   input wire               i_trst_n,
   input wire               o_tdo,
   input wire               o_tdo_oe_n,
   // device status
   input wire               i_config_busy,
   input wire               i_scan_disable,
   input wire               i_power_ok,
   // pins and state
   input wire [BSR_LEN-1:0] i_pin_in,
   input wire [BSR_LEN-1:0] o_pin_oe_n,
   input wire [BSR_LEN-1:0] o_core_in,
   input wire [3:0]         o_tap_state
);
   // one domain, so clock and disable are given once
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // repetition counts leave room for the three-flop synchronisers
   a_reset_tlr: assert property ($rose(i_rst_n) |-> o_tap_state == `ST_TLR)
      else $error("tap not in reset state after reset");
   a_unpowered_float: assert property (!i_power_ok [*6] |-> &o_pin_oe_n)
      else $error("pins driven before power is good");
   a_trst_tlr: assert property (!i_trst_n [*6] |-> o_tap_state == `ST_TLR)
      else $error("test reset did not hold the tap");
   a_lockout_tlr: assert property ((i_config_busy && !i_scan_disable) [*6] |-> o_tap_state == `ST_TLR)
      else $error("scan not locked out during configuration");
   a_idle_tdo_off: assert property (o_tap_state == `ST_RTI |-> o_tdo_oe_n)
      else $error("tdo driven while idle");
   a_tdo_at_fall: assert property (!$stable(o_tdo) |-> !$past(i_tck, 2))
      else $error("tdo changed away from a test clock fall");
   a_core_path: assert property (o_core_in == i_pin_in)
      else $error("core input path disturbed");
   a_tlr_exit: assert property (o_tap_state == `ST_TLR |=> o_tap_state inside {`ST_TLR, `ST_RTI})
      else $error("illegal exit from test logic reset");
   a_ir_shift_exit: assert property (o_tap_state == `ST_SHIFT_IR |=> o_tap_state inside {`ST_SHIFT_IR, `ST_EXIT1_IR})
      else $error("illegal exit from instruction shift");
endmodule // boundary_scan_tap_chk

bind boundary_scan_tap boundary_scan_tap_chk #(.BSR_LEN(BSR_LEN)) u_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(i_tck), .i_trst_n(i_trst_n), .o_tdo(o_tdo),
   .o_tdo_oe_n(o_tdo_oe_n), .i_config_busy(i_config_busy), .i_scan_disable(i_scan_disable),
   .i_power_ok(i_power_ok), .i_pin_in(i_pin_in), .o_pin_oe_n(o_pin_oe_n), .o_core_in(o_core_in),
   .o_tap_state(o_tap_state));

// ---- tb/jtag_ctrl_model.sv ----
// board-level test controller that clocks the port one tck cycle per call
// assumes tck is a plain input sampled by the dut clock; tck stands low between calls
`timescale 1ns/10ps
module jtag_ctrl_model (
   // system clock pacing the test clock
   input  wire i_clk,
   // serial test port
   input  wire i_tdo,
   output reg  o_tck,
   output reg  o_tms,
   output reg  o_tdi
);
   // idle levels match the pull-ups
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end

   // low 5 clk, high 3 clk; 320 ns period
   // tdo taken half a clk after the rise, once the dut's fall update has settled
   task step(input logic tms, input logic tdi, output logic tdo);
      begin
         @(posedge i_clk);
         o_tms <= tms;
         o_tdi <= tdi;
         repeat (4) @(posedge i_clk);
         o_tck <= 1'b1;
         @(negedge i_clk);
         tdo = i_tdo;
         repeat (3) @(posedge i_clk);
         o_tdi <= 1'b1;
         o_tck <= 1'b0;
      end
   endtask
endmodule // jtag_ctrl_model

// ---- tb/tb_boundary_scan_tap.sv ----
// self-checking bench for the boundary-scan port with an 8-cell chain
// assumes the controller model drives tck, tms and tdi; all other inputs driven here
`timescale 1ns/10ps
module tb_boundary_scan_tap;
   localparam BSR_LEN = 8;
   reg               i_clk, i_rst_n, i_trst_n, i_config_busy, i_scan_disable, i_power_ok;
   reg [BSR_LEN-1:0] i_core_out, i_core_oe_n, i_pin_in;
   wire              tck, tms, tdi, o_tdo, o_tdo_oe_n, o_overrun;
   wire [BSR_LEN-1:0] o_pin_out, o_pin_oe_n, o_core_in;
   wire [3:0]        o_tap_state;
   wire              tdo_line;
   int               mismatches, check_count, cycles;
   logic [7:0]       d;
   logic             t;

   // a released tdo shows no stale bit
   assign tdo_line = o_tdo_oe_n ? ~o_tdo : o_tdo;

   jtag_ctrl_model ctl (.i_clk(i_clk), .i_tdo(tdo_line), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
   boundary_scan_tap #(.BSR_LEN(BSR_LEN)) dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(i_trst_n),
      .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .i_config_busy(i_config_busy), .i_scan_disable(i_scan_disable),
      .i_power_ok(i_power_ok), .i_core_out(i_core_out), .i_core_oe_n(i_core_oe_n), .i_pin_in(i_pin_in),
      .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_core_in(o_core_in), .o_overrun(o_overrun),
      .o_tap_state(o_tap_state));

   task report_and_stop;
      begin
         if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         check_count++;
         if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // from idle: capture, shift n bits lsb first, update, back to idle
   task scan(input logic ir, input int n, input logic [7:0] din, output logic [7:0] dout);
      int i;
      begin
         dout = 8'h00;
         ctl.step(1'b1, 1'b1, t);
         if (ir)
            ctl.step(1'b1, 1'b1, t);
         ctl.step(1'b0, 1'b1, t);
         ctl.step(1'b0, 1'b1, t);
         for (i = 0; i < n; i++) begin
            ctl.step(i == n - 1, din[i], t);
            dout[i] = t;
         end
         ctl.step(1'b1, 1'b1, t);
         ctl.step(1'b0, 1'b1, t);
         // the last step reaches the engine and the pins a few clk after tck falls
         repeat (8) @(posedge i_clk);
      end
   endtask

   // pins float until power is good, then follow the core
   task t_power;
      begin
         repeat (8) @(posedge i_clk);
         chk(o_pin_oe_n, 8'hFF);
         chk({4'h0, o_tap_state}, 8'h0F);
         i_power_ok <= 1'b1;
         i_pin_in <= 8'h96;
         repeat (8) @(posedge i_clk);
         chk(o_pin_out, 8'hC3);
         chk(o_pin_oe_n, 8'hF0);
         chk(o_core_in, 8'h96);
         ctl.step(1'b0, 1'b1, t);
      end
   endtask

   // every non-test opcode, bypass included, gives a one-bit delay
   task t_bypass;
      int op;
      begin
         for (op = 2; op < 8; op++) begin
            scan(1'b1, 3, op[7:0], d);
            chk(d, 8'h01);
            scan(1'b0, BSR_LEN, 8'hB4, d);
            chk(d, 8'h68);
            chk(o_pin_out, 8'hC3);
         end
      end
   endtask

   // snapshot and preload, then drive the preload and capture inputs
   task t_sample_extest;
      begin
         i_pin_in <= 8'hA5;
         scan(1'b1, 3, 8'h01, d);
         scan(1'b0, BSR_LEN, 8'h3C, d);
         chk(d, 8'hA5);
         chk(o_pin_out, 8'hC3);
         scan(1'b1, 3, 8'h00, d);
         chk(o_pin_out, 8'h3C);
         chk(o_pin_oe_n, 8'h00);
         i_pin_in <= 8'h5A;
         scan(1'b0, BSR_LEN, 8'hFF, d);
         chk(d, 8'h5A);
         chk(o_pin_out, 8'hFF);
      end
   endtask

   // test reset, scan with support disabled, then lockout must hold the tap against tms low
   task t_lockout;
      int i;
      begin
         i_trst_n <= 1'b0;
         repeat (8) @(posedge i_clk);
         chk({4'h0, o_tap_state}, 8'h0F);
         chk(o_pin_oe_n, 8'hF0);
         i_trst_n <= 1'b1;
         i_config_busy <= 1'b1;
         i_scan_disable <= 1'b1;
         repeat (8) @(posedge i_clk);
         ctl.step(1'b0, 1'b1, t);
         scan(1'b1, 3, 8'h07, d);
         chk(d, 8'h01);
         i_scan_disable <= 1'b0;
         repeat (8) @(posedge i_clk);
         for (i = 0; i < 18; i++)
            ctl.step(1'b0, 1'b1, t);
         chk({4'h0, o_tap_state}, 8'h0F);
         chk({7'h00, o_overrun}, 8'h00);
      end
   endtask

   // clock and hang guard
   always #20 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   initial begin
      i_clk = 1'b0;
      i_rst_n = 1'b0;
      i_trst_n = 1'b1;
      i_config_busy = 1'b0;
      i_scan_disable = 1'b0;
      i_power_ok = 1'b0;
      i_core_out = 8'hC3;
      i_core_oe_n = 8'hF0;
      i_pin_in = 8'h00;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_power();
      t_bypass();
      t_sample_extest();
      t_lockout();
      report_and_stop();
   end
endmodule // tb_boundary_scan_tap
